// ---- verilog/psm_top.sv ----
// Sum-of-products array with ten configurable output cells
`timescale 1ns/1ps
module psm_top #(
   parameter int N_PT = psm_pkg::DEFAULT_PT
) (
   input  wire logic                                             CLOCK_I,
   input  wire logic                                             RESETN_I,
   input  wire logic [psm_pkg::N_DEDICATED-1:0]                  DEDICATED_I,
   input  wire logic [psm_pkg::N_CELL-1:0]                       CELL_IO_PINS_I,
   output logic      [psm_pkg::N_CELL-1:0]                       CELL_IO_PINS_O,
   output logic      [psm_pkg::N_CELL-1:0]                       CELL_IO_PINS_OE_O,
   input  wire logic                                             PRELOAD_ENABLE_LEVEL_I,
   input  wire psm_pkg::psm_cell_cfg_t [psm_pkg::N_CELL-1:0]     CELL_CFG_I,
   input  wire psm_pkg::psm_term_t [psm_pkg::N_CELL-1:0][N_PT-1:0] ARRAY_FUSE_I,
   input  wire psm_pkg::psm_term_t [psm_pkg::N_CELL-1:0]         OE_FUSE_I,
   output logic                                                  POWERUP_DONE_O
);
   import psm_pkg::*;

   initial begin
      if (N_PT < 1 || N_PT > MAX_PT) begin
         $error("N_PT out of range");
      end
   end

   logic [N_CELL-1:0]    reg_q;
   logic [N_CELL-1:0]    reg_d;
   logic [N_CELL-1:0]    pin_q;
   logic [N_CELL-1:0]    pin_d;
   logic [N_CELL-1:0]    oe_q;
   logic [N_CELL-1:0]    oe_d;
   logic                 clk_pin_q;
   logic                 clk_pin_d;
   logic                 done_q;
   logic                 done_d;
   logic [CNT_W-1:0]     cnt_q;
   logic [CNT_W-1:0]     cnt_d;
   psm_state_t           state_q;
   psm_state_t           state_d;

   logic [N_CELL-1:0]    feedback;
   logic [N_SIGNAL-1:0]  array_sig;
   psm_term_t            literal;
   logic [N_CELL-1:0]    sop;
   logic [N_CELL-1:0]    oe_term;
   logic [N_CELL-1:0]    cell_val;
   logic                 dev_clk_rise;
   logic                 outputs_off;

   // Array evaluation
   always_comb begin
      for (int c = 0; c < N_CELL; c++) begin
         if (CELL_CFG_I[c].path_select_bit == PATH_REGISTERED) begin
            feedback[c] = ~reg_q[c];
         end else begin
            feedback[c] = CELL_IO_PINS_I[c];
         end
      end
      array_sig = {feedback, DEDICATED_I};
      for (int s = 0; s < N_SIGNAL; s++) begin
         literal[2*s]   = array_sig[s];
         literal[2*s+1] = ~array_sig[s];
      end
      for (int c = 0; c < N_CELL; c++) begin
         sop[c] = 1'b0;
         for (int p = 0; p < N_PT; p++) begin
            // Unconnected literals pass as 1; both forms of a signal force 0
            sop[c] = sop[c] | (&(~ARRAY_FUSE_I[c][p] | literal));
         end
         oe_term[c] = &(~OE_FUSE_I[c] | literal);
      end
   end

   // Device clock edge and cell values
   always_comb begin
      clk_pin_d    = DEDICATED_I[CLOCK_PIN_IDX];
      dev_clk_rise = DEDICATED_I[CLOCK_PIN_IDX] & ~clk_pin_q;
      outputs_off  = (state_q != PSM_RUN);
      for (int c = 0; c < N_CELL; c++) begin
         reg_d[c] = reg_q[c];
         if (dev_clk_rise && state_q != PSM_CLEARING) begin
            if (PRELOAD_ENABLE_LEVEL_I) begin
               if (CELL_CFG_I[c].path_select_bit == PATH_REGISTERED) begin
                  reg_d[c] = CELL_IO_PINS_I[c];
               end
            end else begin
               reg_d[c] = sop[c];
            end
         end
         if (CELL_CFG_I[c].path_select_bit == PATH_COMBO) begin
            cell_val[c] = sop[c];
         end else begin
            cell_val[c] = reg_q[c];
         end
         if (CELL_CFG_I[c].polarity_select_bit == POL_ACTIVE_LOW) begin
            pin_d[c] = ~cell_val[c];
         end else begin
            pin_d[c] = cell_val[c];
         end
         // Output enables follow the OE term, forced off outside run mode
         oe_d[c] = oe_term[c] & ~outputs_off;
      end
   end

   // Mode sequencing
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      done_d  = done_q;
      case (state_q)
         PSM_CLEARING: begin
            if (cnt_q >= CNT_W'(POWERUP_CLEAR_CYCLES - 1)) begin
               state_d = PSM_RUN;
               done_d  = 1'b1;
               cnt_d   = '0;
            end else begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
         PSM_RUN: begin
            if (PRELOAD_ENABLE_LEVEL_I) begin
               state_d = PSM_PRELOAD;
            end
         end
         PSM_PRELOAD: begin
            if (!PRELOAD_ENABLE_LEVEL_I) begin
               state_d = PSM_SETTLE;
               cnt_d   = '0;
            end
         end
         PSM_SETTLE: begin
            if (PRELOAD_ENABLE_LEVEL_I) begin
               state_d = PSM_PRELOAD;
            end else if (cnt_q >= CNT_W'(PRELOAD_WAIT_CYCLES - 1)) begin
               state_d = PSM_RUN;
               cnt_d   = '0;
            end else begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
         default: begin
            state_d = PSM_CLEARING;
            cnt_d   = '0;
         end
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         reg_q     <= {N_CELL{REG_RESET_VAL}};
         pin_q     <= '0;
         oe_q      <= '0;
         clk_pin_q <= 1'b1;
         done_q    <= 1'b0;
         cnt_q     <= '0;
         state_q   <= PSM_CLEARING;
      end else begin
         reg_q     <= reg_d;
         pin_q     <= pin_d;
         oe_q      <= oe_d;
         clk_pin_q <= clk_pin_d;
         done_q    <= done_d;
         cnt_q     <= cnt_d;
         state_q   <= state_d;
      end
   end

   assign CELL_IO_PINS_O    = pin_q;
   assign CELL_IO_PINS_OE_O = oe_q;
   assign POWERUP_DONE_O    = done_q;

endmodule : psm_top

// ---- verilog/psm_pkg.sv ----
// Constants and types for the sum-of-products macrocell block
package psm_pkg;

   localparam int N_DEDICATED   = 12;
   localparam int N_CELL        = 10;
   localparam int N_SIGNAL      = N_DEDICATED + N_CELL;
   localparam int N_LITERAL     = 2 * N_SIGNAL;
   localparam int MAX_PT        = 16;
   localparam int DEFAULT_PT    = 16;
   localparam int CLOCK_PIN_IDX = 0;

   localparam int CLK_PERIOD_NS         = 10;
   localparam int POWERUP_CLEAR_TIME_NS = 1000;
   localparam int PRELOAD_WAIT_NS       = 100;
   // Longest time rounds down, least time rounds up
   localparam int POWERUP_CLEAR_CYCLES  = POWERUP_CLEAR_TIME_NS / CLK_PERIOD_NS;
   localparam int PRELOAD_WAIT_CYCLES   = (PRELOAD_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W                 = 8;

   // Fuse-derived bit values
   localparam logic FUSE_INTACT     = 1'b0;
   localparam logic FUSE_PROGRAMMED = 1'b1;
   localparam logic PATH_REGISTERED = 1'b0;
   localparam logic PATH_COMBO      = 1'b1;
   localparam logic POL_ACTIVE_LOW  = 1'b0;
   localparam logic POL_ACTIVE_HIGH = 1'b1;
   localparam logic REG_RESET_VAL   = 1'b0;

   // Array fuse: 1 = connected literal, bit 2s true form, bit 2s+1 inverted form
   typedef logic [N_LITERAL-1:0] psm_term_t;

   typedef struct packed {
      logic path_select_bit;
      logic polarity_select_bit;
   } psm_cell_cfg_t;

   typedef enum logic [1:0] {
      PSM_CLEARING,
      PSM_RUN,
      PSM_PRELOAD,
      PSM_SETTLE
   } psm_state_t;

endpackage : psm_pkg

// ---- testbench/psm_checker.sv ----
// Port assertions for the macrocell block
`timescale 1ns/1ps
module psm_checker
   import psm_pkg::*;
(
   input wire logic                           CLOCK_I,
   input wire logic                           RESETN_I,
   input wire logic [N_DEDICATED-1:0]         DEDICATED_I,
   input wire logic [N_CELL-1:0]              CELL_IO_PINS_O,
   input wire logic [N_CELL-1:0]              CELL_IO_PINS_OE_O,
   input wire logic                           PRELOAD_ENABLE_LEVEL_I,
   input wire psm_cell_cfg_t [N_CELL-1:0]     CELL_CFG_I,
   input wire logic                           POWERUP_DONE_O
);
   logic       prev_q;
   logic       rise_q;
   logic [7:0] cnt_q;
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         prev_q <= 1'b1;
         rise_q <= 1'b0;
         cnt_q  <= 8'h00;
      end else begin
         prev_q <= DEDICATED_I[0];
         rise_q <= DEDICATED_I[0] & ~prev_q;
         cnt_q  <= (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
      end
   end
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);
   a_oe_in_clear: assert property (!POWERUP_DONE_O |-> CELL_IO_PINS_OE_O == 10'h000)
      else $error("outputs enabled before clear ended");
   a_done_early: assert property (POWERUP_DONE_O |-> cnt_q >= 8'd99)
      else $error("clear ended too soon");
   a_done_late: assert property (cnt_q >= 8'd102 |-> POWERUP_DONE_O)
      else $error("clear ended too late");
   a_done_stays: assert property (POWERUP_DONE_O |=> POWERUP_DONE_O)
      else $error("done flag dropped");
   a_preload_oe: assert property (PRELOAD_ENABLE_LEVEL_I[*3] |-> CELL_IO_PINS_OE_O == 10'h000)
      else $error("outputs on in preload");
   a_settle_oe: assert property ($fell(PRELOAD_ENABLE_LEVEL_I) |-> (CELL_IO_PINS_OE_O == 10'h000)[*8])
      else $error("outputs on too soon after preload");
   a_reg_hold: assert property (POWERUP_DONE_O && $changed(CELL_IO_PINS_O[0])
      && !CELL_CFG_I[0].path_select_bit |-> $past(rise_q))
      else $error("registered pin moved without clock rise");
   a_clear_pol: assert property ($rose(POWERUP_DONE_O) && !CELL_CFG_I[3].path_select_bit
      |-> CELL_IO_PINS_O[3] == !CELL_CFG_I[3].polarity_select_bit)
      else $error("pin after clear ignores polarity");
endmodule : psm_checker
bind psm_top psm_checker psm_checker_i (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I),
   .DEDICATED_I(DEDICATED_I), .CELL_IO_PINS_O(CELL_IO_PINS_O),
   .CELL_IO_PINS_OE_O(CELL_IO_PINS_OE_O), .PRELOAD_ENABLE_LEVEL_I(PRELOAD_ENABLE_LEVEL_I),
   .CELL_CFG_I(CELL_CFG_I), .POWERUP_DONE_O(POWERUP_DONE_O));

// ---- testbench/psm_board.sv ----
// Board side pin resolution
`timescale 1ns/1ps
module psm_board (
   input  wire logic [9:0] drv_i,
   input  wire logic [9:0] en_i,
   input  wire logic [9:0] ext_i,
   input  wire logic [9:0] ext_en_i,
   output logic      [9:0] pin_o
);
   // Device, then board, else floating pattern
   always_comb begin
      for (int k = 0; k < 10; k++) begin
         pin_o[k] = en_i[k] ? drv_i[k] : (ext_en_i[k] ? ext_i[k] : ~drv_i[k]);
      end
   end
endmodule : psm_board

// ---- testbench/tb.sv ----
// Self-checking testbench for the macrocell block
`timescale 1ns/1ps
module tb;
   import psm_pkg::*;
   logic                       clk = 0;
   logic                       rst_n = 0;
   logic                       pre = 0;
   logic                       done;
   logic [11:0]                ded = 12'h000;
   logic [9:0]                 pin_i, pin_o, oe;
   logic [9:0]                 ext = 10'h000;
   logic [9:0]                 ext_en = 10'h000;
   psm_cell_cfg_t [9:0]        cfg;
   psm_term_t [9:0][1:0]       fuse;
   int                         bad_count = 0;
   int                         checks = 0;
   psm_top #(.N_PT(2)) psm_top_i (.CLOCK_I(clk), .RESETN_I(rst_n), .DEDICATED_I(ded),
      .CELL_IO_PINS_I(pin_i), .CELL_IO_PINS_O(pin_o), .CELL_IO_PINS_OE_O(oe),
      .PRELOAD_ENABLE_LEVEL_I(pre), .CELL_CFG_I(cfg), .ARRAY_FUSE_I(fuse),
      .OE_FUSE_I('0), .POWERUP_DONE_O(done));
   psm_board psm_board_i (.drv_i(pin_o), .en_i(oe), .ext_i(ext), .ext_en_i(ext_en),
      .pin_o(pin_i));
   task automatic chk(string n, logic [9:0] s, logic [9:0] e);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   // Device clock rise, only after clear ended
   task automatic pulse;
      ded[0] = 1'b1;
      @(negedge clk);
      ded[0] = 1'b0;
      repeat (3) @(negedge clk);
   endtask : pulse
   task automatic t_powerup;
      int n;
      n = 0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      while (done !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk("clear", 10'(n), 10'd100);
      @(negedge clk);
      chk("oe", oe, 10'h3FF);
      // Cell 4 fed back floating pin 1 until the enable rose
      @(negedge clk);
      chk("pins", pin_o, 10'h00C);
   endtask : t_powerup
   task automatic t_clocking;
      ded[2:1] = 2'b11;
      pulse();
      chk("pins", pin_o, 10'h017);
      ded[1] = 1'b0;
      pulse();
      chk("pins", pin_o, 10'h01E);
   endtask : t_clocking
   task automatic t_preload;
      pre = 1'b1;
      ext = 10'h009;
      ext_en = 10'h009;
      repeat (3) @(negedge clk);
      chk("oe", oe, 10'h000);
      pulse();
      pre = 1'b0;
      ext_en = 10'h000;
      repeat (5) @(negedge clk);
      chk("oe", oe, 10'h000);
      repeat (10) @(negedge clk);
      chk("oe", oe, 10'h3FF);
      chk("pins", pin_o, 10'h017);
   endtask : t_preload
   initial begin
      for (int c = 0; c < 10; c++) begin
         cfg[c] = 2'b11;
         fuse[c] = {44'h3, 44'h3};
      end
      cfg[0] = 2'b01;
      cfg[1] = 2'b10;
      cfg[3] = 2'b00;
      fuse[0][0] = 44'h4;
      fuse[1][0] = 44'h20;
      fuse[2][0] = 44'h0;
      fuse[3][0] = 44'h40000000;
      fuse[4][0] = 44'h4000000;
   end
   initial forever #5 clk = ~clk;
   initial begin
      #20000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      t_powerup();
      t_clocking();
      t_preload();
      tally_and_finish();
   end
endmodule : tb
